//--- plg_component.sv
// Receiving component end: takes labelled requests and forwards them unaltered.
`timescale 1ns/1ps
module plg_component
  import plg_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Downstream back-pressure.
  input  wire logic        down_ready_i,
  // Request link.
  plg_link_if.component    link,
  // Forwarded request and status.
  output logic             down_valid_o,
  output logic             down_write_o,
  output logic      [31:0] down_addr_o,
  output plg_pid_t         down_pid_o,
  output plg_mg_t          down_mg_o,
  output logic             down_ns_o,
  output logic             range_err_o,
  output logic      [15:0] count_o
);
  // One-entry hold; the bundle is kept whole while buffered.
  logic        v_q, w_q, ns_q, err_q;
  logic [31:0] a_q;
  plg_pid_t    p_q;
  plg_mg_t     m_q;
  logic [15:0] cnt_q;
  wire         acc = link.req_valid && (!v_q || down_ready_i);
  wire  [15:0] lim = link.label_space_nonsecure ? `PLG_CMP_MAX_NS : `PLG_CMP_MAX_S;
  assign link.req_ready = !v_q || down_ready_i;

  // Accept and forward; out-of-range identifiers are flagged, not acted on.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      v_q   <= 1'b0;
      w_q   <= 1'b0;
      ns_q  <= 1'b1;
      err_q <= 1'b0;
      a_q   <= 32'h0;
      p_q   <= `PLG_DEF_PID;
      m_q   <= `PLG_DEF_MG;
      cnt_q <= 16'h0;
    end else if (acc) begin
      v_q   <= 1'b1;
      w_q   <= link.req_write;
      a_q   <= link.req_addr;
      p_q   <= link.partition_id;
      m_q   <= link.monitor_group;
      ns_q  <= link.label_space_nonsecure;
      err_q <= err_q | (link.partition_id > lim);
      cnt_q <= cnt_q + 16'h1;
    end else if (down_ready_i) begin
      v_q <= 1'b0;
    end
  end

  // The label never gates data or ordering, only the side flag.
  assign down_valid_o = v_q;
  assign down_write_o = w_q;
  assign down_addr_o  = a_q;
  assign down_pid_o   = p_q;
  assign down_mg_o    = m_q;
  assign down_ns_o    = ns_q;
  assign range_err_o  = err_q;
  assign count_o      = cnt_q;
endmodule // plg_component

//--- plg_defines.svh
// Constants for the partition label generator and its receiving component.
`ifndef PLG_DEFINES_SVH
`define PLG_DEFINES_SVH
`define PLG_PID_W        16
`define PLG_MG_W         8
`define PLG_DEF_PID      16'h0000
`define PLG_DEF_MG       8'h00
`define PLG_REQ_MAX      16'h00ff
`define PLG_CMP_MAX_NS   16'h003f
`define PLG_CMP_MAX_S    16'h000f
`define PLG_VMAP_N       8
`define PLG_VMAP_W       3
`define PLG_A_CTRL       32'h0000_0000
`define PLG_A_PID        32'h0000_0004
`define PLG_A_MG         32'h0000_0008
`define PLG_A_STAT       32'h0000_000c
`define PLG_A_RIDENT     32'h0000_0010
`define PLG_A_VMAP       32'h0000_0020
`define PLG_A_CIDENT     32'h0000_0040
`define PLG_A_CSIDENT    32'h0000_0044
`define PLG_A_CNT        32'h0000_0048
`define PLG_A_LAST       32'h0000_004c
`endif

//--- plg_link_assertions.sv
// Checker for the partition label link and the bundle forwarded downstream.
`timescale 1ns/1ps
module plg_link_assertions
  import plg_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Link signals.
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        req_write,
  input wire logic [31:0] req_addr,
  input wire plg_pid_t    partition_id,
  input wire plg_mg_t     monitor_group,
  input wire logic        label_space_nonsecure,
  // Forwarded side of the component.
  input wire logic        down_valid_o,
  input wire logic        down_write_o,
  input wire logic [31:0] down_addr_o,
  input wire plg_pid_t    down_pid_o,
  input wire plg_mg_t     down_mg_o,
  input wire logic        down_ns_o,
  input wire logic        range_err_o,
  input wire logic [15:0] count_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Steps of one link transfer.
  sequence s_wait; req_valid && !req_ready; endsequence
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_bad;
    req_valid && req_ready && (label_space_nonsecure ? partition_id > `PLG_CMP_MAX_NS
                                                     : partition_id > `PLG_CMP_MAX_S);
  endsequence
  property p_hold;
    s_wait |=> req_valid && $stable({req_write, req_addr, partition_id, monitor_group,
                                     label_space_nonsecure});
  endproperty
  property p_fwd;
    s_take |=> down_valid_o && down_pid_o == $past(partition_id)
      && down_mg_o == $past(monitor_group) && down_ns_o == $past(label_space_nonsecure);
  endproperty
  property p_fwd_addr;
    s_take |=> down_addr_o == $past(req_addr) && down_write_o == $past(req_write);
  endproperty
  property p_cnt; s_take |=> count_o == $past(count_o) + 16'h0001; endproperty
  property p_cnt_hold; !(req_valid && req_ready) |=> $stable(count_o); endproperty
  property p_range; req_valid |-> partition_id <= `PLG_REQ_MAX; endproperty
  property p_err_set; s_bad |=> range_err_o; endproperty
  property p_err_stick; range_err_o |=> range_err_o; endproperty
  a_hold: assert property (p_hold) else $error("link bundle moved while stalled");
  a_fwd: assert property (p_fwd) else $error("forwarded labels differ");
  a_fwd_addr: assert property (p_fwd_addr) else $error("forwarded request differs");
  a_cnt: assert property (p_cnt) else $error("accept count did not step");
  a_cnt_hold: assert property (p_cnt_hold) else $error("accept count moved");
  a_range: assert property (p_range) else $error("identifier above requester max");
  a_err_set: assert property (p_err_set) else $error("range error not flagged");
  a_err_stick: assert property (p_err_stick) else $error("range error cleared");
endmodule // plg_link_assertions

//--- plg_link_if.sv
// Request link carrying the partition label bundle.
`timescale 1ns/1ps
interface plg_link_if;
  import plg_pkg::*;
  logic     req_valid;
  logic     req_ready;
  logic     req_write;
  logic [31:0] req_addr;
  plg_pid_t partition_id;
  plg_mg_t  monitor_group;
  logic     label_space_nonsecure;
  modport requester (output req_valid, req_write, req_addr, partition_id, monitor_group,
                     output label_space_nonsecure, input req_ready);
  modport component (input req_valid, req_write, req_addr, partition_id, monitor_group,
                     input label_space_nonsecure, output req_ready);
endinterface

//--- plg_pkg.sv
// Types shared by both ends of the partition label link.
package plg_pkg;
  `include "plg_defines.svh"
  typedef logic [`PLG_PID_W-1:0] plg_pid_t;
  typedef logic [`PLG_MG_W-1:0]  plg_mg_t;
  typedef enum logic [1:0] {
    PLG_SP_SEC_PHYS = 2'b00,
    PLG_SP_NS_PHYS  = 2'b01,
    PLG_SP_SEC_VIRT = 2'b10,
    PLG_SP_NS_VIRT  = 2'b11
  } plg_space_t;
  typedef enum logic [0:0] {
    PLG_ST_IDLE = 1'b0,
    PLG_ST_DATA = 1'b1
  } plg_bus_st_t;
endpackage

//--- plg_requester.sv
// Requester end: labels each request with the partition bundle.
//
// Contract
// - Every request carries identifier, group, space bit.
// - Identifier at most sixteen bits wide.
// - Monitoring group at most eight bits wide.
// - Four identifier spaces supported.
// - Security state picks secure or non-secure physical.
// - Virtual space only when virtualization enabled.
// - Valid identifiers run zero to maximum.
// - Software avoids identifiers above smallest maximum.
// - Ident registers report maximum identifiers; only the requester one is decoded, component ones read zero.
// - Default identifier is zero in each space.
// - Disabled generation emits default physical identifier.
// - Identifier error may emit default identifier.
// - Disabled generation emits default monitoring group.
// - Group error: configured or default group.
// - Enabled, no error: configured monitoring group.
// - Masters without support may drive defaults.
// - Bundle encoding agreed by both ends.
// - Interface carries secure or non-secure identifier.
// - Space bit from live security state.
// - Labels never alter memory correctness.
// - Speculative requests use current configuration.
// - Routed or buffered request keeps bundle.
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module plg_requester
  import plg_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // AHB-Lite slave port.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Processing element state.
  input  wire logic        secure_state_i,
  // Request link.
  plg_link_if.requester    link
);
  // Registers: control, configured identifier and group, request issue.
  logic        gen_en_q;
  logic        virt_en_s_q;
  logic        virt_en_ns_q;
  logic        go_q;
  logic        wr_q;
  plg_pid_t    pid_q;
  plg_mg_t     mg_q;
  logic [31:0] addr_q;
  plg_pid_t    vmap_q [`PLG_VMAP_N];
  logic        err_q;
  logic        valid_q;
  plg_pid_t    out_pid_q;
  plg_mg_t     out_mg_q;
  logic        out_ns_q;
  logic        sec_s1_q;
  logic        sec_s2_q;
  logic [31:0] rdata_q;
  logic        ph_q;
  logic        ph_wr_q;
  logic [31:0] ph_addr_q;

  // Security state comes in from another domain; two-stage synchroniser.
  always_ff @(posedge clk_i) begin
    sec_s1_q <= secure_state_i;
    sec_s2_q <= sec_s1_q;
  end

  // Label derivation from live configuration and security state.
  wire       virt_on   = sec_s2_q ? virt_en_s_q : virt_en_ns_q;
  wire       vidx_bad  = pid_q >= plg_pid_t'(`PLG_VMAP_N);
  wire [`PLG_VMAP_W-1:0] vidx = pid_q[`PLG_VMAP_W-1:0];
  plg_pid_t  phys_pid;
  assign phys_pid = virt_on ? vmap_q[vidx] : pid_q;
  // An index past the map or a value above the requester maximum is an error.
  wire       pid_err  = (virt_on && vidx_bad) || (phys_pid > `PLG_REQ_MAX);
  wire       use_def  = !gen_en_q || pid_err;
  plg_pid_t  lbl_pid;
  plg_mg_t   lbl_mg;
  assign lbl_pid = use_def ? `PLG_DEF_PID : phys_pid;
  assign lbl_mg  = use_def ? `PLG_DEF_MG : mg_q;
  // The space bit follows the synchronised security state, never a stored bit.
  wire       lbl_ns  = !sec_s2_q;

  // Bus decode for the address phase.
  wire take    = hsel_i && hready_i && htrans_i[1];
  wire mapped  = ph_addr_q <= `PLG_A_LAST;
  // An issued request that is not yet valid also counts as busy, so that a
  // pipelined second status write cannot overwrite a label still in flight.
  wire busy    = (valid_q && !link.req_ready) || go_q;
  wire stall   = ph_q && ph_wr_q && (ph_addr_q == `PLG_A_STAT) && busy;

  // Address phase capture; data phase completes unless a status write meets a request still busy.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q      <= 1'b0;
      ph_wr_q   <= 1'b0;
      ph_addr_q <= 32'h0;
    end else if (!stall) begin
      ph_q      <= take;
      ph_wr_q   <= hwrite_i;
      ph_addr_q <= haddr_i;
    end
  end

  // Register writes; a write to the status word issues one request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_en_q     <= 1'b0;
      virt_en_s_q  <= 1'b0;
      virt_en_ns_q <= 1'b0;
      pid_q        <= `PLG_DEF_PID;
      mg_q         <= `PLG_DEF_MG;
      addr_q       <= 32'h0;
      go_q         <= 1'b0;
      wr_q         <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (ph_q && ph_wr_q && !stall) begin
        case (ph_addr_q)
          `PLG_A_CTRL: begin
            gen_en_q     <= hwdata_i[0];
            virt_en_s_q  <= hwdata_i[1];
            virt_en_ns_q <= hwdata_i[2];
          end
          `PLG_A_PID: pid_q <= hwdata_i[`PLG_PID_W-1:0];
          `PLG_A_MG:  mg_q  <= hwdata_i[`PLG_MG_W-1:0];
          `PLG_A_STAT: begin
            addr_q <= {hwdata_i[31:1], 1'b0};
            wr_q   <= hwdata_i[0];
            go_q   <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Virtual map entries, one word each.
  for (genvar g = 0; g < `PLG_VMAP_N; g++) begin : g_vmap
    wire hit = ph_q && ph_wr_q && (ph_addr_q == `PLG_A_VMAP + 32'(g * 4));
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        vmap_q[g] <= `PLG_DEF_PID;
      end else if (hit) begin
        vmap_q[g] <= hwdata_i[`PLG_PID_W-1:0];
      end
    end
  end

  // Request issue: labels are registered in the same cycle as valid.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_q   <= 1'b0;
      out_pid_q <= `PLG_DEF_PID;
      out_mg_q  <= `PLG_DEF_MG;
      out_ns_q  <= 1'b1;
      err_q     <= 1'b0;
    end else if (go_q) begin
      valid_q   <= 1'b1;
      out_pid_q <= lbl_pid;
      out_mg_q  <= lbl_mg;
      out_ns_q  <= lbl_ns;
      // The error flag is sticky; only reset clears it.
      err_q     <= err_q | (gen_en_q && pid_err);
    end else if (link.req_ready) begin
      valid_q <= 1'b0;
    end
  end

  // Read decode of the virtual map window; the low address bits pick the entry.
  wire                   rd_vmap = (haddr_i & 32'hffff_ffe3) == `PLG_A_VMAP;
  wire [`PLG_VMAP_W-1:0] rd_vidx = haddr_i[4:2];

  // Read data for the data phase; unmapped words read as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0;
    end else if (take && !hwrite_i) begin
      case (haddr_i)
        `PLG_A_CTRL:   rdata_q <= {29'h0, virt_en_ns_q, virt_en_s_q, gen_en_q};
        `PLG_A_PID:    rdata_q <= 32'(pid_q);
        `PLG_A_MG:     rdata_q <= 32'(mg_q);
        `PLG_A_STAT:   rdata_q <= {29'h0, err_q, out_ns_q, valid_q};
        `PLG_A_RIDENT: rdata_q <= 32'(`PLG_REQ_MAX);
        default:       rdata_q <= rd_vmap ? 32'(vmap_q[rd_vidx]) : 32'h0;
      endcase
    end
  end

  // Bus answer and link outputs.
  assign hrdata_o    = rdata_q;
  assign hreadyout_o = !stall;
  assign hresp_o     = 1'b0;
  assign link.req_valid             = valid_q;
  assign link.req_write             = wr_q;
  assign link.req_addr              = addr_q;
  assign link.partition_id          = out_pid_q;
  assign link.monitor_group         = out_mg_q;
  assign link.label_space_nonsecure = out_ns_q;
  // Transfer size and map limit are unused: every register is one whole word.
  wire unused_ok = mapped | ^hsize_i;
endmodule // plg_requester

//--- testbench.sv
// Self-checking bench for the requester and component joined by the label link.
`timescale 1ns/1ps
module testbench;
  import plg_pkg::*;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, sec, drdy, dv, dw, dns, rerr;
  logic [31:0] haddr, hwdata, hrdata, daddr, seed, r;
  logic [31:0] rs = 32'h507d2e55;
  logic [15:0] cnt;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  plg_pid_t    dpid;
  plg_mg_t     dmg, mg;
  logic [57:0] exp_q[$];
  int          bad_count, n_checks, n_sent, i;
  assign hready = hreadyout;
  plg_link_if link_if();
  plg_requester i_plg_requester(.clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .secure_state_i(sec), .link(link_if));
  plg_component i_plg_component(.clk_i(clk), .rst_i(rst), .down_ready_i(drdy),
    .link(link_if), .down_valid_o(dv), .down_write_o(dw), .down_addr_o(daddr),
    .down_pid_o(dpid), .down_mg_o(dmg), .down_ns_o(dns), .range_err_o(rerr), .count_o(cnt));
  plg_link_assertions i_plg_link_assertions(.clk_i(clk), .rst_i(rst),
    .req_valid(link_if.req_valid), .req_ready(link_if.req_ready),
    .req_write(link_if.req_write), .req_addr(link_if.req_addr),
    .partition_id(link_if.partition_id), .monitor_group(link_if.monitor_group),
    .label_space_nonsecure(link_if.label_space_nonsecure), .down_valid_o(dv),
    .down_write_o(dw), .down_addr_o(daddr), .down_pid_o(dpid), .down_mg_o(dmg),
    .down_ns_o(dns), .range_err_o(rerr), .count_o(cnt));
  // Next state of the pseudo-random generator.
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Compares one result and counts it.
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One single AHB-Lite transfer; waits on hready in both phases.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    chk("hresp", 64'h0, hresp);
  endtask
  // Changes the security state and lets the synchroniser settle.
  task automatic setsec(input logic v);
    sec <= v;
    repeat (3) @(posedge clk);
  endtask
  // Issues one request and notes the bundle that must come out downstream.
  task automatic send(input plg_pid_t p, input plg_mg_t m);
    seed = nx(seed);
    exp_q.push_back({seed[0], seed & 32'hffff_fffe, p, m, ~sec});
    bus(1'b1, `PLG_A_STAT, seed);
    n_sent++;
  endtask
  // Waits until every noted bundle has been seen.
  task automatic drain;
    for (i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("drained", 64'h0, exp_q.size());
  endtask
  // Writes a register and keeps the group value in step.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a == `PLG_A_MG) mg = d[7:0];
  endtask
  // Clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Downstream back-pressure from its own random stream.
  always @(posedge clk) begin
    rs <= nx(rs);
    drdy <= rs[3] | rs[7];
  end
  // Takes the oldest note whenever a bundle leaves downstream.
  always @(posedge clk) begin
    if (!rst && dv === 1'b1 && drdy === 1'b1) begin
      if (exp_q.size() == 0) chk("spare", 64'h0, 64'h1);
      else chk("bundle", exp_q.pop_front(), {dw, daddr, dpid, dmg, dns});
    end
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
  // Main sequence.
  initial begin
    {rst, hsel, hwrite, haddr, hwdata, htrans, sec} = {1'b1, 69'h0};
    hsize = 3'b010;
    seed = 32'h507d2e55;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, `PLG_A_RIDENT, 32'h0);
    chk("rident", 64'h0000_00ff, r);
    bus(1'b0, 32'h0000_0080, 32'h0);
    chk("unmapped", 64'h0, r);
    wr(`PLG_A_PID, 32'h0000_0005);
    wr(`PLG_A_MG, 32'h0000_0003);
    for (int k = 0; k < 2; k++) begin
      setsec(k[0]);
      send(16'h0000, 8'h00);
    end
    wr(`PLG_A_CTRL, 32'h0000_0001);
    for (int k = 0; k < 6; k++) begin
      seed = nx(seed);
      setsec(seed[9]);
      wr(`PLG_A_PID, {28'h0, seed[3:0]});
      wr(`PLG_A_MG, {24'h0, seed[23:16]});
      send({12'h0, seed[3:0]}, mg);
    end
    wr(`PLG_A_CTRL, 32'h0000_0007);
    for (int k = 0; k < 8; k++) begin
      seed = nx(seed);
      setsec(k[0]);
      wr(`PLG_A_VMAP + 4 * k, {28'h0, seed[3:0]});
      bus(1'b0, `PLG_A_VMAP + 4 * k, 32'h0);
      chk("vmap", {60'h0, seed[3:0]}, r);
      wr(`PLG_A_PID, k);
      send({12'h0, seed[3:0]}, mg);
    end
    wr(`PLG_A_CTRL, 32'h0000_0005);
    bus(1'b0, `PLG_A_CTRL, 32'h0);
    chk("ctrl", 64'h5, r);
    wr(`PLG_A_PID, 32'h0000_0009);
    send(16'h0009, mg);
    send(16'h0009, mg);
    wr(`PLG_A_CTRL, 32'h0000_0007);
    wr(`PLG_A_PID, 32'h0000_0008);
    send(16'h0000, 8'h00);
    wr(`PLG_A_CTRL, 32'h0000_0001);
    wr(`PLG_A_PID, 32'h0000_0100);
    send(16'h0000, 8'h00);
    drain();
    bus(1'b0, `PLG_A_STAT, 32'h0);
    chk("stat err", 64'h1, r[2]);
    chk("range ok", 64'h0, rerr);
    setsec(1'b0);
    wr(`PLG_A_PID, 32'h0000_0040);
    send(16'h0040, mg);
    drain();
    chk("range err", 64'h1, rerr);
    chk("count", n_sent, cnt);
    results();
  end
endmodule // testbench
